// ### common/adc_seq_defines.svh
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define OFS_CTRL_ZERO     12'h000
`define OFS_CTRL_TWO      12'h004
`define OFS_RESULT_HIGH   12'h008
`define OFS_RESULT_LOW    12'h00C
`define OFS_TRIG_PIN_SEL  12'h010
`define OFS_IRQ_STATUS    12'h014
`define OFS_IRQ_MASK      12'h018
`define OFS_CLK_SEL       12'h01C
// ****************************************************************
// field positions
// ****************************************************************
`define BIT_CONVERTER_ON  0
`define BIT_GO_DONE       1
`define BIT_COMPLETE      0
`define TRIG_PIN_RESET    5'h14
`define CLK_SEL_RC        1'h1
// ****************************************************************
// timing
// ****************************************************************
`define CLK_PERIOD_NS     25
`define BIT_TIME_NS       200
`define BIT_CYCLES  ((`BIT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### common/adc_seq_pkg.sv
`default_nettype none
package adc_seq_pkg;
    typedef struct packed {
        logic       timer_zero_overflow;
        logic       timer_one_overflow;
        logic       timer_two_match;
        logic       comparator_one_synced;
        logic       comparator_two_synced;
        logic [3:0] pwm_offset_match_event;
        logic [3:0] pwm_match_irq;
    } trig_src_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_CONV = 4'b0010,
        ST_DONE = 4'b0100,
        ST_ABRT = 4'b1000
    } conv_state_t;
endpackage : adc_seq_pkg
`default_nettype wire

// ### hdl/adc_conversion_sequencer.sv
// Chosen here: the APB interface to the registers and the register offsets.
`include "adc_seq_defines.svh"
`default_nettype none
module adc_conversion_sequencer #(
    parameter int RES_BITS = 10,
    parameter int PIN_COUNT = 32
) (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    // apb slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [11:0]             paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    // trigger sources
    input  wire adc_seq_pkg::trig_src_t  trig_src,
    input  wire logic [3:0]              pwm_interrupt_enable,
    input  wire logic [PIN_COUNT-1:0]    port_pins,
    input  wire logic                    waveform_generator_input_pin,
    // analog comparator and power
    input  wire logic                    cmp_hi,
    input  wire logic                    sleep_mode,
    output logic [RES_BITS-1:0]          dac_code,
    output logic                         analog_power,
    output logic                         sample_hold,
    // interrupt and wake
    output logic                         irq,
    output logic                         wake_request
);
    import adc_seq_pkg::*;

    // ****************************************************************
    // registers
    // ****************************************************************
    localparam int BIT_CYC = `BIT_CYCLES;
    logic                   conv_on_q;
    logic                   go_done_q;
    logic [3:0]             trig_sel_q;
    logic [4:0]             pin_sel_q;
    logic                   clk_sel_q;
    logic                   status_q;
    logic                   mask_q;
    logic [RES_BITS-1:0]    result_q;
    logic [RES_BITS-1:0]    sar_q;
    logic [$clog2(RES_BITS+1)-1:0] bit_idx_q;
    logic [7:0]             tick_q;
    logic                   powered_down_q;
    conv_state_t            state_q;

    logic wr_en;
    logic rd_en;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;

    logic go_write_one;
    logic go_write_zero;
    assign go_write_one  = wr_en && paddr == `OFS_CTRL_ZERO
                           && pwdata[`BIT_GO_DONE];
    assign go_write_zero = wr_en && paddr == `OFS_CTRL_ZERO
                           && !pwdata[`BIT_GO_DONE];

    // ****************************************************************
    // trigger selection and edge detection
    // ****************************************************************
    logic [15:0] trig_vec;
    logic [3:0]  pwm_irq_trig;
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_pwm
            assign pwm_irq_trig[g] = |(trig_src.pwm_match_irq[g]
                                       & pwm_interrupt_enable[g]);
        end
    endgenerate

    logic [PIN_COUNT-1:0] pin_meta_q;
    logic [PIN_COUNT-1:0] pin_sync_q;
    logic [1:0]           wgp_sync_q;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_meta_q <= '0;
            pin_sync_q <= '0;
            wgp_sync_q <= 2'h0;
        end
        else
        begin
            // every pin is synchronised before the select mux reads it
            pin_meta_q <= port_pins;
            pin_sync_q <= pin_meta_q;
            wgp_sync_q <= {wgp_sync_q[0], waveform_generator_input_pin};
        end
    end

    // code map: 1 t0, 2 t1, 3 t2, 4 c1, 5 c2, 6..9 pwm offset,
    // 10..13 pwm irq, 14 trigger pin, 15 waveform pin, 0 none
    always_comb
    begin
        trig_vec        = 16'h0000;
        trig_vec[1]     = trig_src.timer_zero_overflow;
        trig_vec[2]     = trig_src.timer_one_overflow;
        trig_vec[3]     = trig_src.timer_two_match;
        trig_vec[4]     = trig_src.comparator_one_synced;
        trig_vec[5]     = trig_src.comparator_two_synced;
        trig_vec[9:6]   = trig_src.pwm_offset_match_event;
        trig_vec[13:10] = pwm_irq_trig;
        trig_vec[14]    = pin_sync_q[pin_sel_q];
        trig_vec[15]    = wgp_sync_q[1];
    end

    logic trig_lvl_q;
    logic trig_old_q;
    logic hw_trigger;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            trig_lvl_q <= 1'b0;
            trig_old_q <= 1'b0;
        end
        else
        begin
            trig_lvl_q <= trig_vec[trig_sel_q];
            trig_old_q <= trig_lvl_q;
        end
    end
    assign hw_trigger = trig_lvl_q && !trig_old_q;

    // ****************************************************************
    // control registers
    // ****************************************************************
    logic start_req;
    logic done_evt;
    logic sleep_abort;
    assign start_req  = conv_on_q && (go_write_one || hw_trigger)
                        && state_q == ST_IDLE;
    assign sleep_abort = sleep_mode && clk_sel_q != `CLK_SEL_RC
                         && state_q == ST_CONV;
    assign done_evt   = state_q == ST_DONE;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            conv_on_q  <= 1'b0;
            trig_sel_q <= 4'h0;
            pin_sel_q  <= `TRIG_PIN_RESET;
            clk_sel_q  <= 1'b0;
            mask_q     <= 1'b0;
        end
        else if (wr_en)
        begin
            case (paddr)
                `OFS_CTRL_ZERO:    conv_on_q  <= pwdata[`BIT_CONVERTER_ON];
                `OFS_CTRL_TWO:     trig_sel_q <= pwdata[3:0];
                `OFS_TRIG_PIN_SEL: pin_sel_q  <= pwdata[4:0];
                `OFS_CLK_SEL:      clk_sel_q  <= pwdata[0];
                `OFS_IRQ_MASK:     mask_q     <= pwdata[`BIT_COMPLETE];
                default:           ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            go_done_q <= 1'b0;
        else if (start_req)
            go_done_q <= 1'b1;
        else if (done_evt || sleep_abort || go_write_zero || !conv_on_q)
            go_done_q <= 1'b0;
    end

    // set wins over clear
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            status_q <= 1'b0;
        else if (done_evt)
            status_q <= 1'b1;
        else if (wr_en && paddr == `OFS_IRQ_STATUS
                 && pwdata[`BIT_COMPLETE])
            status_q <= 1'b0;
    end

    // ****************************************************************
    // successive approximation sequencer
    // ****************************************************************
    logic last_bit;
    assign last_bit = bit_idx_q == '0;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q   <= ST_IDLE;
            sar_q     <= '0;
            bit_idx_q <= '0;
            tick_q    <= 8'h00;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                    if (start_req)
                    begin
                        state_q   <= ST_CONV;
                        sar_q     <= '0;
                        bit_idx_q <= RES_BITS[$bits(bit_idx_q)-1:0];
                        tick_q    <= 8'h00;
                    end
                ST_CONV:
                    if (sleep_abort || go_write_zero || !conv_on_q)
                        state_q <= ST_ABRT;
                    else if (tick_q == 8'(BIT_CYC - 1))
                    begin
                        tick_q <= 8'h00;
                        if (last_bit)
                            state_q <= ST_DONE;
                        else
                        begin
                            sar_q[bit_idx_q-1'b1] <= cmp_hi;
                            bit_idx_q <= bit_idx_q - 1'b1;
                        end
                    end
                    else
                        tick_q <= tick_q + 8'h01;
                ST_DONE: state_q <= ST_IDLE;
                ST_ABRT: state_q <= ST_IDLE;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // fill unresolved bits with the last converted bit
    logic [RES_BITS-1:0] partial;
    always_comb
    begin
        partial = sar_q;
        for (int i = 0; i < RES_BITS; i++)
            if (i < int'(bit_idx_q)
                && bit_idx_q != RES_BITS[$bits(bit_idx_q)-1:0])
                partial[i] = sar_q[bit_idx_q];
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            result_q <= '0;
        else if (done_evt)
            result_q <= sar_q;
        else if (state_q == ST_ABRT)
            result_q <= partial;
    end

    // ****************************************************************
    // analog, sleep and interrupt outputs
    // ****************************************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            powered_down_q <= 1'b0;
            analog_power   <= 1'b0;
            sample_hold    <= 1'b0;
            dac_code       <= '0;
            irq            <= 1'b0;
            wake_request   <= 1'b0;
        end
        else
        begin
            if (!sleep_mode || !conv_on_q)
                powered_down_q <= 1'b0;
            else if ((done_evt && !mask_q) || sleep_abort)
                powered_down_q <= 1'b1;
            analog_power <= conv_on_q && !powered_down_q;
            sample_hold  <= state_q == ST_CONV;
            dac_code     <= bit_idx_q == '0 ? sar_q
                            : sar_q | (RES_BITS'(1) << (bit_idx_q - 1'b1));
            irq          <= status_q && mask_q;
            wake_request <= sleep_mode && status_q && mask_q;
        end
    end

    // ****************************************************************
    // apb read side
    // ****************************************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (psel && !penable && !pwrite)
                case (paddr)
                    `OFS_CTRL_ZERO:    prdata <= {30'h0, go_done_q, conv_on_q};
                    `OFS_CTRL_TWO:     prdata <= {28'h0, trig_sel_q};
                    `OFS_RESULT_HIGH:  prdata <= 32'(result_q >> 8);
                    `OFS_RESULT_LOW:   prdata <= {24'h0, result_q[7:0]};
                    `OFS_TRIG_PIN_SEL: prdata <= {27'h0, pin_sel_q};
                    `OFS_IRQ_STATUS:   prdata <= {31'h0, status_q};
                    `OFS_IRQ_MASK:     prdata <= {31'h0, mask_q};
                    `OFS_CLK_SEL:      prdata <= {31'h0, clk_sel_q};
                    default:           prdata <= 32'h0000_0000;
                endcase
        end
    end
    logic unused_rd;
    assign unused_rd = rd_en;
endmodule : adc_conversion_sequencer
`default_nettype wire

// ### testbench/adc_seq_assertions.sv
`include "adc_seq_defines.svh"
`default_nettype none
// ********
// port checker
// ********
module adc_seq_assertions (
    // bus
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    // converter
    input wire logic        sleep_mode,
    input wire logic        analog_power,
    input wire logic        irq,
    input wire logic        wake_request
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    logic clr_w;
    // only a status or mask write may drop the interrupt
    assign clr_w = psel && penable && pwrite &&
        (paddr == `OFS_IRQ_STATUS || paddr == `OFS_IRQ_MASK);
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("ready late");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    a_no_slave_error: assert property (!pslverr)
        else $error("slave error");
    a_quiet_after_reset:
        assert property ($rose(rst_n) |-> !irq && !wake_request
            && !analog_power) else $error("busy after reset");
    a_irq_clear_cause:
        assert property ($fell(irq) |-> $past(clr_w) || $past(clr_w, 2))
        else $error("irq dropped alone");
    a_wake_in_sleep:
        assert property ($rose(wake_request) |-> sleep_mode
            || $past(sleep_mode)) else $error("wake while awake");
    a_wake_with_irq:
        assert property ($rose(wake_request) |-> ##[0:2] irq)
        else $error("wake without irq");
endmodule : adc_seq_assertions
bind adc_conversion_sequencer adc_seq_assertions adc_seq_assertions_i (
    .clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pready, .pslverr,
    .sleep_mode, .analog_power, .irq, .wake_request
);
`default_nettype wire

// ### testbench/adc_seq_partner.sv
`default_nettype none
// ********
// trigger sources and comparator
// ********
module adc_seq_partner #(
    parameter int RES_BITS = 10
) (
    // clock
    input  wire logic                  clk,
    // analog side
    input  wire logic [RES_BITS-1:0]   dac_code,
    output logic                       cmp_hi,
    // trigger sources
    output var adc_seq_pkg::trig_src_t trig_src,
    output logic [31:0]                port_pins,
    output logic                       wg_pin
);
    timeunit 1ns;
    timeprecision 100ps;
    import adc_seq_pkg::*;
    logic [RES_BITS-1:0] level = '0;
    logic [14:0]         src = '0;
    // input sits half a step above level
    assign cmp_hi = {level, 1'b1} > {dac_code, 1'b0};
    assign trig_src = src[12:0];
    assign port_pins = {11'h0, src[13], 20'h0};
    assign wg_pin = src[14];
    function automatic int bit_of(input int c);
        if (c < 6)
            return 13 - c;
        if (c < 10)
            return c - 2;
        if (c < 14)
            return c - 10;
        return c - 1;
    endfunction : bit_of
    // one edge, held past a whole conversion
    task automatic fire(input int c);
        @(posedge clk);
        src <= 15'h1 << bit_of(c);
        repeat (100) @(posedge clk);
        src <= 15'h0;
    endtask : fire
endmodule : adc_seq_partner
`default_nettype wire

// ### testbench/tb.sv
`include "adc_seq_defines.svh"
`default_nettype none
// ********
// bench top
// ********
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import adc_seq_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic        sleep_mode = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd, port_pins;
    logic        pready, irq, wake_request, analog_power, cmp_hi, wg_pin;
    logic        sample_hold;
    logic [3:0]  pwm_int_en = 4'hF;
    logic [9:0]  dac_code;
    trig_src_t   trig_src;
    int          bad_count = 0;
    int          check_count = 0;
    int          cyc = 0;
    adc_conversion_sequencer #(
        .RES_BITS(10),
        .PIN_COUNT(32)
    ) adc_conversion_sequencer_i (
        .clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr(), .trig_src, .pwm_interrupt_enable(pwm_int_en),
        .port_pins, .waveform_generator_input_pin(wg_pin), .cmp_hi,
        .sleep_mode, .dac_code, .analog_power, .sample_hold, .irq,
        .wake_request
    );
    adc_seq_partner #(.RES_BITS(10)) partner_i (
        .clk, .dac_code, .cmp_hi, .trig_src, .port_pins, .wg_pin
    );
    initial
        forever #12.5 clk = ~clk;
    task automatic summarize();
        if (bad_count == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize
    always @(posedge clk)
    begin
        cyc++;
        if (cyc > 30000)
        begin
            bad_count++;
            summarize();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, g);
        check_count++;
        if (g !== e)
        begin
            bad_count++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), e, rd);
    endtask : rdchk
    task automatic wait_flag();
        for (int i = 0; i < 60 && rd[0] !== 1'b1; i++)
            apb(1'b0, `OFS_IRQ_STATUS, 32'h0);
    endtask : wait_flag
    task automatic t_reset_values();
        for (int a = 0; a < 36; a += 4)
            rdchk(12'(a), a == 16 ? 32'h14 : 32'h0);
        wr(`OFS_CTRL_ZERO, 32'h2);
        repeat (100) @(posedge clk);
        rdchk(`OFS_IRQ_STATUS, 32'h0);
        chk("power", 32'h0, 32'(analog_power));
    endtask : t_reset_values
    task automatic t_conv();
        partner_i.level <= 10'h2A5;
        wr(`OFS_IRQ_MASK, 32'h1);
        wr(`OFS_CTRL_ZERO, 32'h1);
        wr(`OFS_CTRL_ZERO, 32'h3);
        rd = 32'h0;
        wait_flag();
        @(posedge clk);
        chk("irq", 32'h1, 32'(irq));
        rdchk(`OFS_CTRL_ZERO, 32'h1);
        rdchk(`OFS_RESULT_HIGH, 32'h2);
        rdchk(`OFS_RESULT_LOW, 32'hA5);
        wr(`OFS_IRQ_STATUS, 32'h1);
        rdchk(`OFS_IRQ_STATUS, 32'h0);
        chk("irq", 32'h0, 32'(irq));
    endtask : t_conv
    task automatic t_abort();
        logic [9:0] r, e;
        logic       ok;
        ok = 1'b0;
        partner_i.level <= 10'h2C3;
        wr(`OFS_CTRL_ZERO, 32'h3);
        repeat (30) @(posedge clk);
        chk("hold", 32'h1, 32'(sample_hold));
        chk("power", 32'h1, 32'(analog_power));
        wr(`OFS_CTRL_ZERO, 32'h1);
        repeat (4) @(posedge clk);
        chk("hold", 32'h0, 32'(sample_hold));
        apb(1'b0, `OFS_RESULT_HIGH, 32'h0);
        r[9:8] = rd[1:0];
        apb(1'b0, `OFS_RESULT_LOW, 32'h0);
        r[7:0] = rd[7:0];
        // k bits resolved, the rest copy bit 10-k
        for (int k = 2; k < 6; k++)
        begin
            e = 10'h2C3 >> (10 - k) << (10 - k);
            if (e[10 - k])
                e = e | (10'h3FF >> k);
            if (r === e)
                ok = 1'b1;
        end
        chk("abort result", 32'h1, 32'(ok));
        rdchk(`OFS_CTRL_ZERO, 32'h1);
        wr(`OFS_IRQ_STATUS, 32'h1);
    endtask : t_abort
    task automatic t_trig();
        for (int c = 1; c < 16; c++)
        begin
            wr(`OFS_CTRL_TWO, 32'(c));
            partner_i.fire(c % 15 + 1);
            rdchk(`OFS_IRQ_STATUS, 32'h0);
            partner_i.fire(c);
            wait_flag();
            rdchk(`OFS_IRQ_STATUS, 32'h1);
            wr(`OFS_IRQ_STATUS, 32'h1);
            repeat (100) @(posedge clk);
            rdchk(`OFS_IRQ_STATUS, 32'h0);
        end
        // a pwm interrupt whose enable is clear must not start
        pwm_int_en <= 4'hE;
        wr(`OFS_CTRL_TWO, 32'hA);
        partner_i.fire(10);
        rdchk(`OFS_IRQ_STATUS, 32'h0);
        pwm_int_en <= 4'hF;
    endtask : t_trig
    task automatic t_sleep();
        wr(`OFS_CLK_SEL, 32'h1);
        wr(`OFS_CTRL_ZERO, 32'h3);
        sleep_mode <= 1'b1;
        for (int i = 0; i < 150 && wake_request !== 1'b1; i++)
            @(posedge clk);
        chk("wake", 32'h1, 32'(wake_request));
        sleep_mode <= 1'b0;
        wr(`OFS_IRQ_STATUS, 32'h1);
        wr(`OFS_IRQ_MASK, 32'h0);
        wr(`OFS_CTRL_ZERO, 32'h3);
        sleep_mode <= 1'b1;
        repeat (150) @(posedge clk);
        chk("power", 32'h0, 32'(analog_power));
        rdchk(`OFS_IRQ_STATUS, 32'h1);
        rdchk(`OFS_CTRL_ZERO, 32'h1);
        sleep_mode <= 1'b0;
        wr(`OFS_IRQ_STATUS, 32'h1);
        wr(`OFS_CLK_SEL, 32'h0);
        wr(`OFS_IRQ_MASK, 32'h1);
        wr(`OFS_CTRL_ZERO, 32'h3);
        repeat (20) @(posedge clk);
        sleep_mode <= 1'b1;
        repeat (150) @(posedge clk);
        chk("power", 32'h0, 32'(analog_power));
        chk("wake", 32'h0, 32'(wake_request));
        rdchk(`OFS_IRQ_STATUS, 32'h0);
        rdchk(`OFS_CTRL_ZERO, 32'h1);
        sleep_mode <= 1'b0;
    endtask : t_sleep
    task automatic t_mid_reset();
        wr(`OFS_CTRL_ZERO, 32'h3);
        repeat (20) @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rdchk(`OFS_CTRL_ZERO, 32'h0);
        rdchk(`OFS_CTRL_TWO, 32'h0);
        rdchk(`OFS_TRIG_PIN_SEL, 32'h14);
        repeat (100) @(posedge clk);
        rdchk(`OFS_IRQ_STATUS, 32'h0);
    endtask : t_mid_reset
    initial
    begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_reset_values();
        t_conv();
        t_abort();
        t_trig();
        t_sleep();
        t_mid_reset();
        summarize();
    end
endmodule : tb
`default_nettype wire
